// [mrsc_regs.vh]
`ifndef MRSC_REGS_VH
`define MRSC_REGS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define MRSC_OFF_CTRL      8'h00
`define MRSC_OFF_STATUS    8'h04
`define MRSC_OFF_SCANREQ   8'h08
`define MRSC_OFF_MIB       8'h0c
`define MRSC_OFF_RANGE     8'h10
`define MRSC_OFF_RCLKOPT   8'h14
`define MRSC_OFF_HDR       8'h18
`define MRSC_OFF_HDRINFO   8'h1c
`define MRSC_OFF_HDRQUAL   8'h20
// ----------------------------------------
// CTRL bits (write 1 to request)
// ----------------------------------------
`define MRSC_CTRL_RANGE_END 0
`define MRSC_CTRL_MAC_RST   1
`define MRSC_CTRL_SCAN      2
// ----------------------------------------
// STATUS bits
// ----------------------------------------
`define MRSC_ST_RANGE_CNF   0
`define MRSC_ST_RST_CNF     1
`define MRSC_ST_RST_OK      2
`define MRSC_ST_SCAN_CNF    3
`define MRSC_ST_SCAN_OK     4
`define MRSC_ST_HDR_VALID   5
`define MRSC_ST_RANGE_RUN   6
`define MRSC_ST_LINK_EN     7
`define MRSC_ST_SWEEP_LSB   8
// ----------------------------------------
// Sweep settings
// ----------------------------------------
`define MRSC_SWEEP_DISABLED 2'h0
`define MRSC_SWEEP_ONLY     2'h1
`define MRSC_SWEEP_OUTSIDE  2'h2
`define MRSC_SWEEP_IDLE     2'h3
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define MRSC_MIB_RESET      3'h0
`define MRSC_RCLK_RESET     7'h00
`define MRSC_RST_CYCLES     4'h8
`define MRSC_SCAN_TIMEOUT   16'h0400
`endif

// [mrsc_mac_reset_scan.v]
`include "mrsc_regs.vh"

module mrsc_mac_reset_scan #(
  parameter CHAN_W    = 8,
  parameter HDR_W     = 32,
  parameter SCAN_TMO  = `MRSC_SCAN_TIMEOUT
)(
  input  wire              clk,
  input  wire              rst_n,
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire [31:0]       rangeCountIn,
  output reg               rangeTimerRun,
  input  wire              beaconPeriodActive,
  input  wire              trafficScheduled,
  input  wire              scanStateReached,
  input  wire              hdrRxPulse,
  input  wire [HDR_W-1:0]  hdrRxData,
  input  wire [CHAN_W-1:0] hdrRxChannel,
  input  wire [15:0]       hdrRxDelta,
  input  wire [7:0]        hdrRxQuality,
  input  wire [7:0]        hdrRxStrength,
  output reg               macResetPulse,
  output reg               bufferFlush,
  output reg               linkEnable,
  output reg               scanActive,
  output reg  [CHAN_W-1:0] scanChannel
);

  // ----------------------------------------
  // Pin input synchronisers
  // ----------------------------------------
  reg [3:0] syncA_reg;
  reg [3:0] syncB_reg;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_reg <= 4'h0;
      syncB_reg <= 4'h0;
    end
    else
    begin
      syncA_reg <= {hdrRxPulse, scanStateReached, trafficScheduled,
                    beaconPeriodActive};
      syncB_reg <= syncA_reg;
    end
  end
  wire bpSync    = syncB_reg[0];
  wire schedSync = syncB_reg[1];
  wire reachSync = syncB_reg[2];
  wire hdrSync   = syncB_reg[3];
  reg  hdrPrev_reg;
  wire hdrEvent  = hdrSync & ~hdrPrev_reg;

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  reg        awHave_reg;
  reg        wHave_reg;
  reg  [7:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg  [3:0] wStrb_reg;
  assign s_axi_awready = ~awHave_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHave_reg & ~s_axi_bvalid;
  wire doWrite = awHave_reg & wHave_reg & ~s_axi_bvalid;
  wire wrCtrl  = doWrite & (awAddr_reg == `MRSC_OFF_CTRL) & wStrb_reg[0];

  function isMapped;
    input [7:0] a;
    begin
      isMapped = (a[1:0] == 2'h0) && (a <= `MRSC_OFF_HDRQUAL);
    end
  endfunction

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_RESET = 2'h1;
  localparam ST_SCAN  = 2'h2;
  reg  [1:0]        state_reg;
  reg  [3:0]        rstCnt_reg;
  reg  [15:0]       tmo_reg;
  reg  [1:0]        sweep_reg;
  reg  [1:0]        reqSweep_reg;
  reg  [CHAN_W-1:0] reqChan_reg;
  reg  [2:0]        mib_reg;
  reg  [6:0]        rclkOpt_reg;
  reg  [7:0]        status_reg;
  reg  [HDR_W-1:0]  hdr_reg;
  reg  [CHAN_W-1:0] hdrChan_reg;
  reg  [15:0]       hdrDelta_reg;
  reg  [7:0]        hdrQual_reg;
  reg  [7:0]        hdrRssi_reg;

  wire reqRange = wrCtrl & wData_reg[`MRSC_CTRL_RANGE_END]
                  & ~status_reg[`MRSC_ST_RANGE_CNF];
  wire reqReset = wrCtrl & wData_reg[`MRSC_CTRL_MAC_RST]
                  & (state_reg == ST_IDLE);
  wire reqScan  = wrCtrl & wData_reg[`MRSC_CTRL_SCAN]
                  & (state_reg == ST_IDLE) & ~reqReset;
  wire clrSt    = doWrite & (awAddr_reg == `MRSC_OFF_STATUS)
                  & wStrb_reg[0];

  // Inactive timer bits forced to zero
  function [31:0] rangeMask;
    input [6:0] o;
    begin
      rangeMask        = 32'h0003fff8;
      rangeMask[2]     = o[2] | o[3] | o[4];
      rangeMask[1]     = o[3] | o[4];
      rangeMask[0]     = o[4];
      rangeMask[23:18] = {6{o[5]}};
      rangeMask[31:24] = {8{o[6]}};
      if (!o[0])
        rangeMask = 32'h00000000;
    end
  endfunction
  wire [31:0] rangeVal = rangeCountIn & rangeMask(rclkOpt_reg);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHave_reg    <= 1'b0;
      wHave_reg     <= 1'b0;
      awAddr_reg    <= 8'h00;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      state_reg     <= ST_IDLE;
      rstCnt_reg    <= 4'h0;
      tmo_reg       <= 16'h0000;
      sweep_reg     <= `MRSC_SWEEP_DISABLED;
      reqSweep_reg  <= `MRSC_SWEEP_DISABLED;
      reqChan_reg   <= {CHAN_W{1'b0}};
      scanChannel   <= {CHAN_W{1'b0}};
      mib_reg       <= `MRSC_MIB_RESET;
      rclkOpt_reg   <= `MRSC_RCLK_RESET;
      status_reg    <= 8'h00;
      rangeTimerRun <= 1'b1;
      macResetPulse <= 1'b0;
      bufferFlush   <= 1'b0;
      linkEnable    <= 1'b0;
      hdrPrev_reg   <= 1'b0;
      hdr_reg       <= {HDR_W{1'b0}};
      hdrChan_reg   <= {CHAN_W{1'b0}};
      hdrDelta_reg  <= 16'h0000;
      hdrQual_reg   <= 8'h00;
      hdrRssi_reg   <= 8'h00;
    end
    else
    begin
      hdrPrev_reg   <= hdrSync;
      macResetPulse <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHave_reg   <= 1'b0;
        wHave_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddr_reg) ? 2'h0 : 2'h2;
        if (awAddr_reg == `MRSC_OFF_SCANREQ && wStrb_reg[0])
        begin
          reqChan_reg  <= wData_reg[CHAN_W-1:0];
          reqSweep_reg <= wData_reg[17:16];
        end
        if (awAddr_reg == `MRSC_OFF_MIB && wStrb_reg[0])
          mib_reg <= {wData_reg[2:1] == 2'h3 ? 2'h2 : wData_reg[2:1],
                      wData_reg[0]};
        if (awAddr_reg == `MRSC_OFF_RCLKOPT && wStrb_reg[0])
          rclkOpt_reg <= wData_reg[6:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;

      // Write 1 clears status; new events win over clears
      if (clrSt)
        status_reg <= status_reg & ~wData_reg[7:0];

      if (reqRange)
      begin
        rangeTimerRun <= 1'b0;
        status_reg[`MRSC_ST_RANGE_CNF] <= 1'b1;
      end

      if (hdrEvent && sweep_reg != `MRSC_SWEEP_DISABLED
          && state_reg != ST_RESET)
      begin
        hdr_reg      <= hdrRxData;
        hdrChan_reg  <= hdrRxChannel;
        hdrDelta_reg <= hdrRxDelta;
        hdrQual_reg  <= hdrRxQuality;
        hdrRssi_reg  <= hdrRxStrength;
        status_reg[`MRSC_ST_HDR_VALID] <= 1'b1;
      end

      case (state_reg)
        ST_IDLE:
        begin
          if (reqReset)
          begin
            state_reg     <= ST_RESET;
            rstCnt_reg    <= `MRSC_RST_CYCLES;
            macResetPulse <= 1'b1;
            bufferFlush   <= 1'b1;
            linkEnable    <= 1'b0;
          end
          else if (reqScan)
          begin
            state_reg   <= ST_SCAN;
            tmo_reg     <= SCAN_TMO;
            scanChannel <= reqChan_reg;
            linkEnable  <= 1'b1;
          end
          else if (reqRange && sweep_reg != `MRSC_SWEEP_ONLY)
            linkEnable  <= 1'b1;
        end
        ST_RESET:
        begin
          if (rstCnt_reg == 4'h0)
          begin
            state_reg   <= ST_IDLE;
            bufferFlush <= 1'b0;
            status_reg[`MRSC_ST_RST_CNF] <= 1'b1;
            status_reg[`MRSC_ST_RST_OK]  <= 1'b1;
          end
          else
            rstCnt_reg <= rstCnt_reg - 4'h1;
          sweep_reg     <= `MRSC_SWEEP_DISABLED;
          reqSweep_reg  <= `MRSC_SWEEP_DISABLED;
          mib_reg       <= `MRSC_MIB_RESET;
          rclkOpt_reg   <= `MRSC_RCLK_RESET;
          rangeTimerRun <= 1'b1;
          scanChannel   <= {CHAN_W{1'b0}};
        end
        ST_SCAN:
        begin
          if (reachSync || reqSweep_reg == `MRSC_SWEEP_DISABLED)
          begin
            state_reg <= ST_IDLE;
            sweep_reg <= reqSweep_reg;
            if (reqSweep_reg == `MRSC_SWEEP_ONLY)
              linkEnable <= 1'b0;
            status_reg[`MRSC_ST_SCAN_CNF] <= 1'b1;
            status_reg[`MRSC_ST_SCAN_OK]  <= 1'b1;
          end
          else if (tmo_reg == 16'h0000)
          begin
            state_reg <= ST_IDLE;
            status_reg[`MRSC_ST_SCAN_CNF] <= 1'b1;
            status_reg[`MRSC_ST_SCAN_OK]  <= 1'b0;
          end
          else
            tmo_reg <= tmo_reg - 16'h0001;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Scan gating by sweep setting
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      scanActive <= 1'b0;
    else
      case (sweep_reg)
        `MRSC_SWEEP_ONLY:    scanActive <= 1'b1;
        `MRSC_SWEEP_OUTSIDE: scanActive <= ~bpSync;
        `MRSC_SWEEP_IDLE:    scanActive <= ~schedSync;
        default:             scanActive <= 1'b0;
      endcase
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  reg [31:0] rdMux;
  always @*
  begin
    case (s_axi_araddr)
      `MRSC_OFF_STATUS:  rdMux = {22'h0, sweep_reg, linkEnable,
                                  rangeTimerRun, status_reg[5:0]};
      `MRSC_OFF_SCANREQ: rdMux = {14'h0, reqSweep_reg, 8'h00, 8'h00}
                                 | {{(32-CHAN_W){1'b0}}, reqChan_reg};
      `MRSC_OFF_MIB:     rdMux = {29'h0, mib_reg};
      `MRSC_OFF_RANGE:   rdMux = rangeVal;
      `MRSC_OFF_RCLKOPT: rdMux = {25'h0, rclkOpt_reg};
      `MRSC_OFF_HDR:     rdMux = hdr_reg[31:0];
      `MRSC_OFF_HDRINFO: rdMux = {hdrDelta_reg, 8'h00,
                                  hdrChan_reg[7:0]};
      `MRSC_OFF_HDRQUAL: rdMux = {16'h0, hdrRssi_reg, hdrQual_reg};
      default:           rdMux = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= isMapped(s_axi_araddr) ? 2'h0 : 2'h2;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // mrsc_mac_reset_scan

// [mrsc_mac_reset_scan_chk.sv]
module mrsc_mac_reset_scan_chk (
  input wire        clk,
  input wire        rst_n,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        macResetPulse,
  input wire        bufferFlush,
  input wire        linkEnable,
  input wire        scanActive
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rst_flush: assert property
    (macResetPulse |-> ##[0:1] bufferFlush) else $error("no flush");
  a_pulse_one: assert property
    (macResetPulse |=> !macResetPulse) else $error("long reset pulse");
  a_flush_len: assert property
    ($rose(bufferFlush) |-> bufferFlush[*8]) else $error("short flush");
  a_link_off: assert property
    (bufferFlush |-> !linkEnable) else $error("link on in flush");
  a_scan_off: assert property
    ($fell(bufferFlush) |-> ##1 !scanActive) else $error("scan after reset");
  a_wr_latency: assert property
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
     |-> ##2 s_axi_bvalid) else $error("late write answer");
  a_wr_busy: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write taken");
  a_rd_latency: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("late read answer");
  a_rd_hold: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cover property (macResetPulse);
  cover property (scanActive);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // mrsc_mac_reset_scan_chk

bind mrsc_mac_reset_scan mrsc_mac_reset_scan_chk u_chk (.clk, .rst_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .macResetPulse,
  .bufferFlush, .linkEnable, .scanActive);

// [mrsc_radio_model.sv]
module mrsc_radio_model (
  input  wire logic   clk,
  input  wire logic   reachEn,
  output logic        scanStateReached,
  output logic        hdrRxPulse,
  output logic [31:0] hdrRxData,
  output logic [7:0]  hdrRxChannel,
  output logic [15:0] hdrRxDelta,
  output logic [7:0]  hdrRxQuality,
  output logic [7:0]  hdrRxStrength
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] lag = 3'h0;
  initial
  begin
    hdrRxPulse = 1'b0;
    {hdrRxData, hdrRxChannel, hdrRxDelta, hdrRxQuality, hdrRxStrength} = '0;
  end
  // Radio settles a few cycles after being asked; never if not allowed
  always @(posedge clk) lag <= {lag[1:0], reachEn};
  assign scanStateReached = lag[2];
  task automatic sendHdr(input logic [31:0] h, input logic [7:0] c,
                         input logic [15:0] o, input logic [7:0] q, s);
    @(posedge clk);
    {hdrRxData, hdrRxChannel, hdrRxDelta, hdrRxQuality,
     hdrRxStrength} <= {h, c, o, q, s};
    hdrRxPulse <= 1'b1;
    repeat (6) @(posedge clk);
    hdrRxPulse <= 1'b0;
    repeat (2) @(posedge clk);
    // Fields stale now: show their inverse
    {hdrRxData, hdrRxChannel, hdrRxDelta, hdrRxQuality,
     hdrRxStrength} <= ~{h, c, o, q, s};
  endtask
endmodule // mrsc_radio_model

// [tb_top.sv]
`include "mrsc_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, reachEn = 0;
  logic beaconPeriodActive = 0, trafficScheduled = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, scanChannel, ch;
  logic [31:0] s_axi_wdata = 0, rangeCountIn = 32'hffffffff;
  logic [31:0] s_axi_rdata, st, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rangeTimerRun, macResetPulse, bufferFlush;
  logic linkEnable, scanActive, scanStateReached, hdrRxPulse;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [31:0] hdrRxData;
  logic [7:0] hdrRxChannel, hdrRxQuality, hdrRxStrength;
  logic [15:0] hdrRxDelta;
  int errCount = 0, nChecks = 0, sw, k;

  mrsc_mac_reset_scan #(.SCAN_TMO(16'h0010)) u_mrsc_mac_reset_scan (.*);
  mrsc_radio_model u_mrsc_radio_model (.*);

  initial forever #10 clk = ~clk;

  task automatic wrapUp;
    $display("checks=%0d errors=%0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic hang;
    errCount++;
    wrapUp;
  endtask
  task automatic chk(input logic [31:0] g, e);
    nChecks++;
    if (g !== e)
    begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    br = s_axi_bresp;
    s_axi_bready <= 0;
    if (n == 40) hang;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    if (n == 40) hang;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  task automatic waitSt(input int b);
    int n;
    for (n = 0; n < 60; n++)
    begin
      rd(`MRSC_OFF_STATUS, st);
      if (st[b]) break;
    end
    if (n == 60) hang;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    rdChk(`MRSC_OFF_STATUS, 32'h40);
    rdChk(`MRSC_OFF_MIB, 32'h0);
    rdChk(8'h24, 32'h0);
    chk(32'(rr), 32'h2);
    wr(8'h24, 32'h0);
    chk(32'(br), 32'h2);
    wr(`MRSC_OFF_MIB, 32'h7);
    chk(32'(br), 32'h0);
    rdChk(`MRSC_OFF_MIB, 32'h5);
    wr(`MRSC_OFF_RCLKOPT, 32'h3);
    rdChk(`MRSC_OFF_RANGE, 32'h0003fff8);
    wr(`MRSC_OFF_RCLKOPT, 32'h25);
    rdChk(`MRSC_OFF_RANGE, 32'h00fffffc);
    wr(`MRSC_OFF_CTRL, 32'h1);
    waitSt(`MRSC_ST_RANGE_CNF);
    chk(32'(rangeTimerRun), 32'h0);
    wr(`MRSC_OFF_STATUS, 32'h3f);
    // Radio never settles: change must give up
    wr(`MRSC_OFF_SCANREQ, 32'h10005);
    wr(`MRSC_OFF_CTRL, 32'h4);
    waitSt(`MRSC_ST_SCAN_CNF);
    chk(32'(st[`MRSC_ST_SCAN_OK]), 32'h0);
    for (sw = 0; sw < 4; sw++)
    begin
      ch = 8'h20 + 8'(sw);
      wr(`MRSC_OFF_STATUS, 32'h3f);
      reachEn <= 1;
      wr(`MRSC_OFF_SCANREQ, {14'h0, 2'(sw), 8'h0, ch});
      wr(`MRSC_OFF_CTRL, 32'h4);
      waitSt(`MRSC_ST_SCAN_CNF);
      chk(st & 32'h318, {22'h0, 2'(sw), 8'h18});
      if (sw != 0) chk(32'(scanChannel), 32'(ch));
      if (sw == 1) chk(32'(linkEnable), 32'h0);
      for (k = 0; k < 3; k++)
      begin
        beaconPeriodActive <= (k == 1);
        trafficScheduled <= (k == 2);
        repeat (6) @(posedge clk);
        chk(32'(scanActive), 32'(sw != 0 && !(sw == 2 && k == 1)
            && !(sw == 3 && k == 2)));
      end
      trafficScheduled <= 0;
      reachEn <= 0;
      repeat (8) @(posedge clk);
    end
    u_mrsc_radio_model.sendHdr(32'ha5c30f12, 8'h2b, 16'hfffe, 8'h7f, 8'hc4);
    waitSt(`MRSC_ST_HDR_VALID);
    rdChk(`MRSC_OFF_HDR, 32'ha5c30f12);
    rdChk(`MRSC_OFF_HDRINFO, 32'hfffe002b);
    rdChk(`MRSC_OFF_HDRQUAL, 32'h0000c47f);
    wr(`MRSC_OFF_STATUS, 32'h3f);
    wr(`MRSC_OFF_MIB, 32'h3);
    wr(`MRSC_OFF_CTRL, 32'h2);
    waitSt(`MRSC_ST_RST_CNF);
    chk(st & 32'h306, 32'h6);
    chk(32'(linkEnable), 32'h0);
    chk(32'(rangeTimerRun), 32'h1);
    rdChk(`MRSC_OFF_MIB, 32'h0);
    rdChk(`MRSC_OFF_RCLKOPT, 32'h0);
    u_mrsc_radio_model.sendHdr(32'h1, 8'h1, 16'h1, 8'h1, 8'h1);
    repeat (4) @(posedge clk);
    rd(`MRSC_OFF_STATUS, st);
    chk(32'(st[`MRSC_ST_HDR_VALID]), 32'h0);
    wrapUp;
  end
endmodule // tb_top
